/* File: dcq_bidir_ports.sv */
// Port qualification, data drive and flag logic of two opposed queues
module dcq_bidir_ports
	import dcq_pkg::*;
#(
	parameter int DEPTH = DEPTH_DEF,
	parameter int PW = $clog2(DEPTH) + 1
)
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic porta_clock,
	input wire logic porta_chip_select_n,
	input wire logic porta_write_not_read,
	input wire logic porta_enable,
	input wire logic porta_mailbox_select,
	input wire logic [DATA_W-1:0] porta_data_in,
	output logic [DATA_W-1:0] porta_data_out,
	output logic porta_data_oe,
	output logic porta_empty_outready,
	output logic porta_full_inready,
	output logic porta_almost_empty_n,
	output logic porta_almost_full_n,
	input wire logic portb_clock,
	input wire logic portb_chip_select_n,
	input wire logic portb_read_not_write,
	input wire logic portb_enable,
	input wire logic portb_mailbox_select,
	input wire logic [DATA_W-1:0] portb_data_in,
	output logic [DATA_W-1:0] portb_data_out,
	output logic portb_data_oe,
	output logic portb_empty_outready,
	output logic portb_full_inready,
	output logic portb_almost_empty_n,
	output logic portb_almost_full_n,
	input wire logic first_word_fall_through,
	input wire logic [PW-1:0] btoa_empty_threshold_a2b,
	input wire logic [PW-1:0] empty_threshold_b2a,
	input wire logic [PW-1:0] full_threshold_a2b,
	input wire logic [PW-1:0] full_threshold_b2a
);
	localparam int AW = PW - 1;
	localparam logic [PW-1:0] FULL_CNT = PW'(DEPTH);
	localparam int SW = 2 + 2 * (4 + DATA_W) + 1 + 4 * PW;

	// All pins arrive from foreign clocks: two stages before any use
	logic [SW-1:0] sync_s1_r;
	logic [SW-1:0] sync_s2_r;
	logic [1:0] pclk_s3_r;
	// Counts three edges after reset, until the stages hold real pin samples
	logic [1:0] warm_r;
	wire warm;
	wire [SW-1:0] sync_in;

	wire [1:0] pclk_s;
	wire a_cs_n_s;
	wire a_wnr_s;
	wire a_en_s;
	wire a_mb_s;
	wire [DATA_W-1:0] a_din_s;
	wire b_cs_n_s;
	wire b_rnw_s;
	wire b_en_s;
	wire b_mb_s;
	wire [DATA_W-1:0] b_din_s;
	wire first_word_fall_through_s;
	wire [PW-1:0] x1_s;
	wire [PW-1:0] x2_s;
	wire [PW-1:0] y1_s;
	wire [PW-1:0] y2_s;

	// Field order must mirror the unpack below, one field per line
	assign sync_in = {
		porta_clock,
		portb_clock,
		porta_chip_select_n,
		porta_write_not_read,
		porta_enable,
		porta_mailbox_select,
		porta_data_in,
		portb_chip_select_n,
		portb_read_not_write,
		portb_enable,
		portb_mailbox_select,
		portb_data_in,
		first_word_fall_through,
		btoa_empty_threshold_a2b,
		empty_threshold_b2a,
		full_threshold_a2b,
		full_threshold_b2a
	};

	assign {
		pclk_s[PORT_A],
		pclk_s[PORT_B],
		a_cs_n_s,
		a_wnr_s,
		a_en_s,
		a_mb_s,
		a_din_s,
		b_cs_n_s,
		b_rnw_s,
		b_en_s,
		b_mb_s,
		b_din_s,
		first_word_fall_through_s,
		x1_s,
		x2_s,
		y1_s,
		y2_s
	} = sync_s2_r;

	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			sync_s1_r <= '0;
			sync_s2_r <= '0;
			pclk_s3_r <= 2'h0;
			warm_r <= 2'h0;
		end
		else
		begin
			sync_s1_r <= sync_in;
			sync_s2_r <= sync_s1_r;
			pclk_s3_r <= pclk_s;
			warm_r <= warm_r + {1'b0, ~warm};
		end
	end

	// Per-port decode, indexed by port
	wire [1:0] tick;
	wire [1:0] wr_qual;
	wire [1:0] rd_qual;
	wire [1:0] oe_nxt;
	wire [DATA_W-1:0] din [2];

	// Rising port clock seen after synchronisation; data was sampled alongside it
	// Stages hold reset zeros at first, so a pin already high would pose as a rise
	assign warm = (warm_r == 2'h3);
	assign tick = pclk_s & ~pclk_s3_r & {warm, warm};

	// Selects are only looked at on enabled edges, so they may move while enable is low
	assign wr_qual[PORT_A] = ~a_cs_n_s & a_wnr_s & a_en_s & ~a_mb_s; // RULE23 RULE6
	assign rd_qual[PORT_A] = ~a_cs_n_s & ~a_wnr_s & a_en_s & ~a_mb_s; // RULE1 RULE6
	assign wr_qual[PORT_B] = ~b_cs_n_s & ~b_rnw_s & b_en_s & ~b_mb_s; // RULE2 RULE4
	assign rd_qual[PORT_B] = ~b_cs_n_s & b_rnw_s & b_en_s & ~b_mb_s; // RULE2 RULE5
	// Drive follows the select levels alone; enable plays no part in tristate control
	assign oe_nxt[PORT_A] = ~a_cs_n_s & ~a_wnr_s;
	assign oe_nxt[PORT_B] = ~b_cs_n_s & b_rnw_s; // RULE3
	assign din[PORT_A] = a_din_s;
	assign din[PORT_B] = b_din_s;

	// Per-queue state, indexed by queue; oe_r alone is indexed by port
	wire [1:0] eo_r;
	wire [1:0] fi_r;
	wire [1:0] ae_n_r;
	wire [1:0] af_n_r;
	logic [1:0] oe_r;
	wire [DATA_W-1:0] dout_r [2];
	wire [PW-1:0] xth [2];
	wire [PW-1:0] yth [2];

	assign xth[Q_A2B] = x1_s; // RULE24
	assign yth[Q_A2B] = y1_s; // RULE24
	assign xth[Q_B2A] = x2_s; // RULE21
	assign yth[Q_B2A] = y2_s; // RULE21

	always_ff @(posedge mclk)
	begin
		if (!resetn)
			oe_r <= {OE_RST, OE_RST};
		else
			oe_r <= oe_nxt; // RULE3
	end

	genvar q;
	generate
		for (q = 0; q < 2; q++)
		begin : g_queue
			localparam int WP = q;
			localparam int RP = 1 - q;

			// Depth follows the parameter; the pointers carry one wrap bit
			logic [DATA_W-1:0] mem [DEPTH]; // RULE25
			logic [PW-1:0] aptr_r;
			logic [PW-1:0] wptr_r;
			logic [PW-1:0] rptr_r;
			logic [PW-1:0] wptr_rd1_r;
			logic [PW-1:0] wptr_rd2_r;
			logic [PW-1:0] rptr_wr1_r;
			logic eo_nxt;
			wire buf_s_ready;
			wire buf_m_valid;
			wire [DATA_W-1:0] buf_m_data;

			// Each queue owns its flag flops; the shared vectors only gather them
			logic eo_q_r;
			logic fi_q_r;
			logic ae_n_q_r;
			logic af_n_q_r;
			logic [DATA_W-1:0] dout_q_r;

			assign eo_r[q] = eo_q_r;
			assign fi_r[q] = fi_q_r;
			assign ae_n_r[q] = ae_n_q_r;
			assign af_n_r[q] = af_n_q_r;
			assign dout_r[q] = dout_q_r;

			// Accept only with input-ready high and buffer room, so no word is dropped
			wire acc = tick[WP] & wr_qual[WP] & fi_r[q] & buf_s_ready; // RULE17 RULE4 RULE23
			wire [PW-1:0] aptr_nxt = aptr_r + {{(PW-1){1'b0}}, acc}; // RULE18
			wire mem_room = ((wptr_r - rptr_r) != FULL_CNT);
			wire drain = buf_m_valid & mem_room;

			dcq_skid2 #(
				.W(DATA_W)
			) u_skid (
				.mclk(mclk),
				.resetn(resetn),
				.s_valid(acc),
				.s_ready(buf_s_ready),
				.s_data(din[WP]),
				.m_valid(buf_m_valid),
				.m_ready(mem_room),
				.m_data(buf_m_data)
			);

			// Reader side: both modes are looked at on reader edges only
			wire first_word_fall_through_avail = (wptr_rd2_r != rptr_r);
			wire ld_std = tick[RP] & ~first_word_fall_through_s & rd_qual[RP] & eo_r[q]; // RULE9 RULE12
			wire ld_first_word_fall_through = tick[RP] & first_word_fall_through_s & first_word_fall_through_avail & (~eo_r[q] | rd_qual[RP]); // RULE7 RULE8 RULE14
			wire ld = ld_std | ld_first_word_fall_through;
			wire [PW-1:0] rptr_nxt = rptr_r + {{(PW-1){1'b0}}, ld}; // RULE13
			// Output register is excluded from the stored count
			wire [PW-1:0] rd_cnt = wptr_rd1_r - rptr_nxt; // RULE22
			wire [PW-1:0] wr_cnt = aptr_nxt - rptr_wr1_r; // RULE22

			always_comb
			begin
				eo_nxt = eo_r[q];
				if (tick[RP])
				begin
					if (!first_word_fall_through_s)
						eo_nxt = (wptr_rd1_r != rptr_nxt); // RULE15 RULE13
					else if (ld)
						eo_nxt = 1'b1; // RULE14 RULE11
					else if (rd_qual[RP])
						eo_nxt = 1'b0; // RULE11
				end
			end

			always_ff @(posedge mclk)
			begin
				if (drain)
					mem[wptr_r[AW-1:0]] <= buf_m_data;
			end

			always_ff @(posedge mclk)
			begin
				if (!resetn)
				begin
					aptr_r <= '0;
					wptr_r <= '0;
					rptr_r <= '0;
				end
				else
				begin
					aptr_r <= aptr_nxt; // RULE18
					wptr_r <= wptr_r + {{(PW-1){1'b0}}, drain};
					rptr_r <= rptr_nxt; // RULE13
				end
			end

			// Pointer copies step only on the far port's edges: a late write waits one edge
			always_ff @(posedge mclk)
			begin
				if (!resetn)
				begin
					wptr_rd1_r <= '0;
					wptr_rd2_r <= '0;
					rptr_wr1_r <= '0;
				end
				else
				begin
					if (tick[RP])
					begin
						wptr_rd1_r <= wptr_r; // RULE10 RULE16
						wptr_rd2_r <= wptr_rd1_r; // RULE10 RULE14
					end
					if (tick[WP])
						rptr_wr1_r <= rptr_r; // RULE10 RULE20
				end
			end

			// Reader-side flags and output register
			always_ff @(posedge mclk)
			begin
				if (!resetn)
				begin
					eo_q_r <= FLAG_RST;
					ae_n_q_r <= FLAG_RST;
					dout_q_r <= DOUT_RST;
				end
				else
				begin
					eo_q_r <= eo_nxt;
					if (tick[RP])
						ae_n_q_r <= (rd_cnt > xth[q]); // RULE21 RULE24
					if (ld)
						dout_q_r <= mem[rptr_r[AW-1:0]]; // RULE1 RULE5
				end
			end

			// Writer-side flags, stepped on the writer's edges
			always_ff @(posedge mclk)
			begin
				if (!resetn)
				begin
					fi_q_r <= FLAG_RST;
					af_n_q_r <= FLAG_RST;
				end
				else if (tick[WP])
				begin
					fi_q_r <= (wr_cnt != FULL_CNT) & buf_s_ready; // RULE17 RULE19 RULE18
					af_n_q_r <= (wr_cnt < (FULL_CNT - yth[q])); // RULE21 RULE24
				end
			end
		end
	endgenerate

	// Port A reads B-to-A and writes A-to-B; port B the reverse
	assign porta_data_out = dout_r[Q_B2A]; // RULE1
	assign porta_data_oe = oe_r[PORT_A];
	assign porta_empty_outready = eo_r[Q_B2A]; // RULE10
	assign porta_almost_empty_n = ae_n_r[Q_B2A];
	assign porta_full_inready = fi_r[Q_A2B];
	assign porta_almost_full_n = af_n_r[Q_A2B];
	assign portb_data_out = dout_r[Q_A2B]; // RULE5
	assign portb_data_oe = oe_r[PORT_B];
	assign portb_empty_outready = eo_r[Q_A2B]; // RULE10
	assign portb_almost_empty_n = ae_n_r[Q_A2B];
	assign portb_full_inready = fi_r[Q_B2A];
	assign portb_almost_full_n = af_n_r[Q_B2A];
endmodule

/* File: dcq_pkg.sv */
// Shared constants for the bidirectional queue port and flag logic
// Notes on behaviour
// RULE1: Port A qualified read loads next B-to-A word onto port A outputs.
// RULE2: Port B controls match port A, but its direction select is inverted.
// RULE3: Port B data driven only with chip select low and read selected.
// RULE4: Port B qualified write with input-ready high stores word into B-to-A queue.
// RULE5: Port B qualified read presents next A-to-B word; independent of port A.
// RULE6: Outside party changes chip and direction selects only while enable is low.
// RULE7: Fall-through mode auto-loads first word on the edge raising output-ready.
// RULE8: Fall-through mode with output-ready high advances only on qualified reads.
// RULE9: Standard mode loads output register only on qualified reads.
// RULE10: Each flag passes two stages and is timed by its own port clock.
// RULE11: Output-ready high means fresh word; low holds old word, ignores reads.
// RULE12: Empty flag high means word in memory; low holds old word, ignores reads.
// RULE13: Read pointer advances per output load; pointers compared for empty states.
// RULE14: Fall-through word appears on third reading edge, with output-ready rising.
// RULE15: Standard empty flag rises on second reading edge after a write.
// RULE16: Edges too close to the write push synchronisation to the next edge.
// RULE17: Input-ready high means a free location; low ignores writes.
// RULE18: Write pointer advances per accepted write; pointers compared for full states.
// RULE19: Input-ready rises on second writing edge after a read frees a slot.
// RULE20: Writing edges too close to the read push synchronisation one edge later.
// RULE21: B-to-A flags follow the empty, almost-empty, almost-full, full count bands.
// RULE22: Word held in the output register is not counted as stored.
// RULE23: Port A qualified write with input-ready high stores word into A-to-B queue.
// RULE24: A-to-B queue uses its own empty and full thresholds, same bands.
// RULE25: Queue depth and pointer width are parameters; comparisons scale with them.
package dcq_pkg;
	localparam int DATA_W = 36;
	localparam int DEPTH_DEF = 16384;
	localparam int PORT_A = 0;
	localparam int PORT_B = 1;
	localparam int Q_A2B = 0;
	localparam int Q_B2A = 1;
	localparam logic FLAG_RST = 1'b0;
	localparam logic OE_RST = 1'b0;
	localparam logic [DATA_W-1:0] DOUT_RST = 36'h0;
endpackage

/* File: dcq_skid2.sv */
// Two-entry buffer between write acceptance and the queue memory
module dcq_skid2
	import dcq_pkg::*;
#(
	parameter int W = DATA_W
)
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic s_valid,
	output logic s_ready,
	input wire logic [W-1:0] s_data,
	output logic m_valid,
	input wire logic m_ready,
	output logic [W-1:0] m_data
);
	logic [W-1:0] ent_r [2];
	logic wp_r;
	logic rp_r;
	logic [1:0] cnt_r;
	logic [1:0] cnt_nxt;
	wire push = s_valid & s_ready;
	wire pop = m_valid & m_ready;

	assign s_ready = (cnt_r != 2'h2);
	assign m_valid = (cnt_r != 2'h0);
	assign m_data = ent_r[rp_r];
	assign cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};

	always_ff @(posedge mclk)
	begin
		if (push)
			ent_r[wp_r] <= s_data;
	end

	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			wp_r <= 1'b0;
			rp_r <= 1'b0;
			cnt_r <= 2'h0;
		end
		else
		begin
			wp_r <= wp_r ^ push;
			rp_r <= rp_r ^ pop;
			cnt_r <= cnt_nxt;
		end
	end
endmodule

/* File: dcq_bidir_ports_chk.sv */
// Port-level checker for the bidirectional queue block
module dcq_bidir_ports_chk
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic porta_clock,
	input wire logic porta_chip_select_n,
	input wire logic porta_write_not_read,
	input wire logic [35:0] porta_data_out,
	input wire logic porta_data_oe,
	input wire logic porta_full_inready,
	input wire logic portb_clock,
	input wire logic portb_chip_select_n,
	input wire logic portb_read_not_write,
	input wire logic portb_enable,
	input wire logic portb_mailbox_select,
	input wire logic [35:0] portb_data_out,
	input wire logic portb_data_oe,
	input wire logic portb_empty_outready,
	input wire logic portb_almost_full_n,
	input wire logic first_word_fall_through
);
	timeunit 1ns;
	timeprecision 1ps;
	logic pa_d_r, pb_d_r;
	logic [3:0] ca_r, cb_r, ca_nxt, cb_nxt;
	logic [2:0] bq_r;
	// Cycles since each raw port clock rise; outputs may only move shortly after one
	assign ca_nxt = (porta_clock && !pa_d_r) ? 4'h0 : ca_r + {3'h0, ca_r != 4'hF};
	assign cb_nxt = (portb_clock && !pb_d_r) ? 4'h0 : cb_r + {3'h0, cb_r != 4'hF};
	always_ff @(posedge mclk)
	begin
		pa_d_r <= porta_clock;
		pb_d_r <= portb_clock;
		bq_r <= {bq_r[1:0], !portb_chip_select_n && portb_read_not_write && portb_enable && !portb_mailbox_select};
		ca_r <= resetn ? ca_nxt : 4'hF;
		cb_r <= resetn ? cb_nxt : 4'hF;
	end
	default clocking dcb @(posedge mclk);
	endclocking
	default disable iff (!resetn);
	sequence s_a_drv;
		!porta_chip_select_n && !porta_write_not_read;
	endsequence
	sequence s_a_flt;
		porta_chip_select_n || porta_write_not_read;
	endsequence
	sequence s_b_drv;
		!portb_chip_select_n && portb_read_not_write;
	endsequence
	sequence s_b_load;
		$changed(portb_data_out) && !first_word_fall_through;
	endsequence
	a_oea_drive: assert property (s_a_drv [*5] |-> porta_data_oe)
		else $error("port A bus idle during read select");
	a_oea_float: assert property (s_a_flt [*5] |-> !porta_data_oe)
		else $error("port A bus driven while deselected");
	a_oeb_drive: assert property (s_b_drv [*5] |-> portb_data_oe)
		else $error("port B bus idle during read select");
	a_fla_stands: assert property ($changed(porta_full_inready) |-> ca_r inside {[4'h1:4'h5]})
		else $error("port A input ready moved off its clock");
	a_efb_stands: assert property ($changed(portb_empty_outready) |-> cb_r inside {[4'h1:4'h5]})
		else $error("port B empty flag moved off its clock");
	a_afb_stands: assert property ($changed(portb_almost_full_n) |-> cb_r inside {[4'h1:4'h5]})
		else $error("port B almost full moved off its clock");
	a_doa_stands: assert property ($changed(porta_data_out) |-> ca_r inside {[4'h1:4'h5]})
		else $error("port A data moved off its clock");
	a_dob_std_read: assert property (s_b_load |-> bq_r[2])
		else $error("port B data loaded without a read");
endmodule
bind dcq_bidir_ports dcq_bidir_ports_chk i_chk (.*);

/* File: dcq_host.sv */
// Far-side model: free-running port clocks of the two hosts
module dcq_host
(
	input wire logic mclk,
	output logic porta_clock,
	output logic portb_clock
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] div_a_r = 4'h0;
	logic [3:0] div_b_r = 4'h0;
	// Unequal periods keep the two ports out of step
	always @(posedge mclk)
	begin
		div_a_r <= (div_a_r == 4'h9) ? 4'h0 : div_a_r + 4'h1;
		div_b_r <= (div_b_r == 4'hD) ? 4'h0 : div_b_r + 4'h1;
	end
	assign porta_clock = div_a_r < 4'h5;
	assign portb_clock = div_b_r < 4'h7;
endmodule

/* File: dcq_bidir_ports_tb.sv */
// Testbench for the bidirectional queue ports and flags
module dcq_bidir_ports_tb
	import dcq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int DEPTH = 16;
	localparam int PW = 5;
	logic mclk, resetn, porta_clock, portb_clock, first_word_fall_through;
	logic porta_chip_select_n, porta_write_not_read, porta_enable, porta_mailbox_select;
	logic portb_chip_select_n, portb_read_not_write, portb_enable, portb_mailbox_select;
	logic [DATA_W-1:0] porta_data_in, porta_data_out, portb_data_in, portb_data_out, pa_last, pb_last, d;
	logic porta_data_oe, porta_empty_outready, porta_full_inready, porta_almost_empty_n, porta_almost_full_n;
	logic portb_data_oe, portb_empty_outready, portb_full_inready, portb_almost_empty_n, portb_almost_full_n;
	logic [PW-1:0] btoa_empty_threshold_a2b = 5'h04, empty_threshold_b2a = 5'h04;
	logic [PW-1:0] full_threshold_a2b = 5'h04, full_threshold_b2a = 5'h04;
	logic [DATA_W-1:0] qa[$], qb[$];
	int failures, n_compared, seed, k;
	dcq_bidir_ports #(.DEPTH(DEPTH), .PW(PW)) i_dut (.*);
	dcq_host i_host (.*);
	initial
	begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	task automatic chk(input string nm, input logic [DATA_W-1:0] seen, exp);
		n_compared++;
		if (seen !== exp)
		begin
			failures++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One port cycle; controls change only at the falling port edge
	task automatic op(input bit pb, input logic [3:0] c, input bit push);
		if (pb)
			@(negedge portb_clock);
		else
			@(negedge porta_clock);
		#2;
		d = {8'(k), 28'($random(seed))};
		k++;
		if (pb)
		begin
			{portb_chip_select_n, portb_read_not_write, portb_enable, portb_mailbox_select} = c;
			portb_data_in = d;
			if (push) qa.push_back(d);
		end
		else
		begin
			{porta_chip_select_n, porta_write_not_read, porta_enable, porta_mailbox_select} = c;
			porta_data_in = d;
			if (push) qb.push_back(d);
		end
	endtask
	// Deselect with enable low, so select changes never qualify an edge
	task automatic idle(input int n);
		op(0, 4'h8, 0);
		op(1, 4'h8, 0);
		repeat (n) @(negedge portb_clock);
		#2;
	endtask
	task automatic close_out;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Every new output word must be the oldest one written
	always @(posedge mclk)
	begin
		if (resetn && porta_data_out !== pa_last)
			chk("a data", porta_data_out, (qa.size() > 0) ? qa.pop_front() : ~porta_data_out);
		if (resetn && portb_data_out !== pb_last)
			chk("b data", portb_data_out, (qb.size() > 0) ? qb.pop_front() : ~portb_data_out);
		pa_last <= resetn ? porta_data_out : 36'h0;
		pb_last <= resetn ? portb_data_out : 36'h0;
	end
	initial
	begin
		#200000;
		failures++;
		close_out;
	end
	initial
	begin
		seed = 14;
		k = 1;
		resetn = 1'b0;
		first_word_fall_through = 1'b0;
		{porta_chip_select_n, porta_write_not_read, porta_enable, porta_mailbox_select} = 4'h8;
		{portb_chip_select_n, portb_read_not_write, portb_enable, portb_mailbox_select} = 4'h8;
		porta_data_in = 36'h0;
		portb_data_in = 36'h0;
		repeat (3) @(posedge mclk);
		#2 resetn = 1'b1;
		idle(3);
		op(0, 4'h7, 0);
		op(0, 4'h4, 0);
		for (int i = 0; i <= DEPTH; i++) op(0, 4'h6, i < DEPTH);
		idle(4);
		chk("a full", porta_full_inready, 1'b0);
		chk("a almost full", porta_almost_full_n, 1'b0);
		chk("b empty", portb_empty_outready, 1'b1);
		chk("b almost empty", portb_almost_empty_n, 1'b1);
		for (int i = 0; i <= DEPTH; i++) op(1, 4'h6, 0);
		chk("b oe", portb_data_oe, 1'b1);
		idle(4);
		chk("b empty", portb_empty_outready, 1'b0);
		chk("b almost empty", portb_almost_empty_n, 1'b0);
		chk("a full", porta_full_inready, 1'b1);
		chk("a almost full", porta_almost_full_n, 1'b1);
		chk("b left", 36'(qb.size()), 36'h0);
		chk("b oe", portb_data_oe, 1'b0);
		resetn = 1'b0;
		first_word_fall_through = 1'b1;
		repeat (3) @(posedge mclk);
		#2 resetn = 1'b1;
		idle(3);
		for (int i = 0; i < 3; i++) op(1, 4'h2, 1);
		idle(5);
		chk("a ready", porta_empty_outready, 1'b1);
		chk("a almost empty", porta_almost_empty_n, 1'b0);
		for (int i = 0; i < 15; i++) op(1, 4'h2, i < 14);
		idle(4);
		chk("b full", portb_full_inready, 1'b0);
		chk("b almost full", portb_almost_full_n, 1'b0);
		chk("a almost empty", porta_almost_empty_n, 1'b1);
		for (int i = 0; i <= DEPTH; i++) op(0, 4'h2, 0);
		chk("a oe", porta_data_oe, 1'b1);
		idle(4);
		chk("a ready", porta_empty_outready, 1'b0);
		chk("b full", portb_full_inready, 1'b1);
		chk("b almost full", portb_almost_full_n, 1'b1);
		chk("a left", 36'(qa.size()), 36'h0);
		close_out;
	end
endmodule
